// ### logic/frfr_regs.sv
// Rate, precompensation, data port and diagnostic input registers
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
// What this block does
// - Last rate register write sets data rate
// - Rate/precomp keeps on soft reset, 02h hard
// - Bit 7 pulses controller reset, self-clears
// - Bit 6 enters manual low power
// - Soft reset or port access leaves low power
// - Bits 4:2 pick precompensation delay code
// - Default delay depends on data rate
// - Precompensation starts at track 0, programmable
// - Two bits encode rate; FM 11 illegal
// - Rate-only register: keeps soft, 250k hard
// - Buffer used only in execution phase
// - Soft reset keeps locked buffer enable
// - Hard reset: buffer off, threshold zero
// - Burst request holds until burst done
// - Non-burst request drops 350 ns between
// - Buffering disabled separately for reads, writes
// - Input status bit 7 shows disk changed
// - Compatible mode drives bits 6:0 as zero
// - Alternate mode: 6:3 ones, 2:1 rate
// - Alternate bit 0 high for slow rates
// - Config bit zero enables, one disables buffer
// - Threshold 0-15, kept under lock
module frfr_regs
#(
  parameter int GAP_COUNT = frfr_pkg::GAP_CYCLES
)
(
  input  wire logic       clk,             // 250 MHz clock
  input  wire logic       reset_n,         // Hardware reset, async active low
  input  wire logic [2:0] addr,            // Register address
  input  wire logic [7:0] wrData,          // Write data
  input  wire logic       wrStrobe,        // Write strobe
  input  wire logic       rdStrobe,        // Read strobe
  input  wire logic       cfgSpace,        // Selects internal config registers
  input  wire logic       diskChangedIn,   // Disk changed drive input
  input  wire logic       dorReset,        // Digital output reset request
  input  wire logic       xferDone,        // Core finished one buffer burst
  input  wire logic       byteWanted,      // Core has a byte to move
  input  wire logic       xferIsRead,      // Execution transfer is a disk read
  input  wire logic [7:0] mainStatusIn,    // Main status value from the core
  input  wire logic [7:0] coreDataIn,      // Result or read byte from the core
  output logic [7:0]      rdData,          // Read data, cycle after strobe
  output logic            rdDataOe_n,      // Low while read data driven
  output logic [7:0]      portData,        // Byte written to data port
  output logic            portWrite,       // Data port write pulse
  output logic            softReset,       // Controller reset pulse
  output logic            lowPower,        // Oscillator and separator off
  output logic [1:0]      rateSelect,      // Active data rate code
  output logic [2:0]      precompCode,     // Resolved precompensation code
  output logic [7:0]      precompTrack,    // First precompensated track
  output logic            bufferActive,    // Buffer in use for transfer
  output logic [3:0]      bufferThreshold, // Effective threshold
  output logic            transferRequest, // DMA or interrupt request
  output logic            rateIllegal      // FM with 1 Mbps code
);

  logic [7:0] ratePrecomp_ff;
  logic [1:0] rate_ff;
  logic       lowPower_ff;
  logic       softReset_ff;
  logic       bufDisable_ff;
  logic       bufLock_ff;
  logic [3:0] buffer_threshold_ff;
  logic [4:0] modeCfg_ff;
  logic [7:0] preTrack_ff;
  logic [1:0] phase_ff;
  logic [7:0] rdData_ff;
  logic       rdOe_ff;
  logic [7:0] portData_ff;
  logic       portWrite_ff;
  logic [2:0] precomp_ff;
  logic       bufActive_ff;
  logic [3:0] effThresh_ff;
  logic       illegal_ff;
  frfr_pkg::frfr_req_e reqState_ff;
  logic [15:0] gapCount_ff;

  logic wrRate;
  logic wrRateOnly;
  logic portAccess;
  logic msrRead;
  logic swReset;
  logic portWr;
  logic cfgWrBuf;
  logic cfgWrMode;
  logic cfgWrTrack;
  logic cfgWrPhase;
  logic reqOn_ff;
  frfr_pkg::frfr_req_e nxt_reqState;
  logic [15:0]         nxt_gapCount;

  function automatic logic [2:0] resolvePrecomp(input logic [2:0] code, input logic [1:0] rate);
    if (code != frfr_pkg::PRECOMP_DEFAULT)
      resolvePrecomp = code;
    else if (rate == frfr_pkg::RATE_1M)
      resolvePrecomp = frfr_pkg::PRECOMP_STEP1;
    else
      resolvePrecomp = frfr_pkg::PRECOMP_STEP3;
  endfunction : resolvePrecomp

  // Device and config space share addresses, so every decode also checks the space select
  function automatic logic regHit(input logic       strobe,
                                  input logic       inCfg,
                                  input logic       wantCfg,
                                  input logic [2:0] at,
                                  input logic [2:0] want);
    regHit = strobe && inCfg == wantCfg && at == want;
  endfunction : regHit

  assign wrRate     = regHit(wrStrobe, cfgSpace, 1'b0, addr, frfr_pkg::ADDR_RATE_PRECOMP);
  assign wrRateOnly = regHit(wrStrobe, cfgSpace, 1'b0, addr, frfr_pkg::ADDR_RATE_SELECT);
  assign portAccess = regHit(wrStrobe || rdStrobe, cfgSpace, 1'b0, addr,
                             frfr_pkg::ADDR_DATA_PORT);
  assign msrRead    = regHit(rdStrobe, cfgSpace, 1'b0, addr, frfr_pkg::ADDR_MAIN_STATUS);
  assign portWr     = regHit(wrStrobe, cfgSpace, 1'b0, addr, frfr_pkg::ADDR_DATA_PORT);
  assign cfgWrBuf   = regHit(wrStrobe, cfgSpace, 1'b1, addr, frfr_pkg::ADDR_BUF_CONFIG);
  assign cfgWrMode  = regHit(wrStrobe, cfgSpace, 1'b1, addr, frfr_pkg::ADDR_MODE_CONFIG);
  assign cfgWrTrack = regHit(wrStrobe, cfgSpace, 1'b1, addr, frfr_pkg::ADDR_PRECOMP_TRACK);
  assign cfgWrPhase = regHit(wrStrobe, cfgSpace, 1'b1, addr, frfr_pkg::ADDR_PHASE);
  // Soft reset from either source acts one cycle after the write
  assign swReset    = softReset_ff;

  // Rate/precomp register: untouched by soft reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ratePrecomp_ff <= frfr_pkg::RATE_PRECOMP_RST;
    else if (wrRate)
      ratePrecomp_ff <= {2'h0, wrData[5:0]};
  end

  // Whichever rate register was written last wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rate_ff <= frfr_pkg::RATE_RST;
    else if (wrRate || wrRateOnly)
      rate_ff <= wrData[1:0];
  end

  // One-cycle pulse, so the reset bit clears itself with no stored state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      softReset_ff <= 1'b0;
    else
      softReset_ff <= (wrRate && wrData[frfr_pkg::SWRESET_BIT]) || dorReset;
  end

  // A same-cycle low-power write wins over any waking access or soft reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      lowPower_ff <= 1'b0;
    else if (wrRate && wrData[frfr_pkg::LOWPOWER_BIT])
      lowPower_ff <= 1'b1;
    else if (swReset || portAccess || msrRead)
      lowPower_ff <= 1'b0;
  end

  // Configuration state: buffer enable, lock, threshold, mode, start track
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bufDisable_ff <= 1'b1;
      buffer_threshold_ff     <= frfr_pkg::BUFFER_THRESHOLD_RST;
      bufLock_ff    <= 1'b0;
      modeCfg_ff    <= 5'h00;
      preTrack_ff   <= frfr_pkg::PRE_TRACK_RST;
    end
    else if (cfgWrBuf)
    begin
      bufDisable_ff <= wrData[frfr_pkg::BUF_DISABLE_BIT];
      bufLock_ff    <= wrData[frfr_pkg::BUF_LOCK_BIT];
      buffer_threshold_ff     <= wrData[3:0];
    end
    else if (cfgWrMode)
      modeCfg_ff <= wrData[4:0];
    else if (cfgWrTrack)
      preTrack_ff <= wrData;
    else if (swReset && !bufLock_ff)
    begin
      bufDisable_ff <= 1'b1;
      buffer_threshold_ff     <= frfr_pkg::BUFFER_THRESHOLD_RST;
    end
  end

  // Soft reset always drops back to the command phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_ff <= frfr_pkg::FRFR_PH_COMMAND;
    else if (swReset)
      phase_ff <= frfr_pkg::FRFR_PH_COMMAND;
    else if (cfgWrPhase)
      phase_ff <= wrData[1:0];
  end

  // Buffer only serves execution phase and when this direction allows it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bufActive_ff <= 1'b0;
      effThresh_ff <= 4'h0;
    end
    else
    begin
      bufActive_ff <= !bufDisable_ff && phase_ff == frfr_pkg::FRFR_PH_EXECUTION
                      && !(xferIsRead ? modeCfg_ff[frfr_pkg::RD_BUF_OFF_BIT]
                                      : modeCfg_ff[frfr_pkg::WR_BUF_OFF_BIT]);
      // Disabled buffer counts as zero threshold for the service window
      effThresh_ff <= bufDisable_ff ? 4'h0 : buffer_threshold_ff;
    end
  end

  // Resolved two cycles after the write, so the drive never sees a half-written code
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      precomp_ff <= frfr_pkg::PRECOMP_STEP3;
      illegal_ff <= 1'b0;
    end
    else
    begin
      precomp_ff <= resolvePrecomp(ratePrecomp_ff[frfr_pkg::PRECOMP_HI:frfr_pkg::PRECOMP_LO],
                                   rate_ff);
      illegal_ff <= modeCfg_ff[frfr_pkg::FM_BIT] && rate_ff == frfr_pkg::RATE_1M;
    end
  end

  // Request sequencer: burst holds, non-burst inserts a quiet gap per byte
  always_comb
  begin
    nxt_reqState = reqState_ff;
    nxt_gapCount = gapCount_ff;
    if (swReset)
    begin
      nxt_reqState = frfr_pkg::FRFR_REQ_IDLE;
      nxt_gapCount = 16'h0000;
    end
    else
    begin
      case (reqState_ff)
        frfr_pkg::FRFR_REQ_IDLE:
          if (byteWanted)
            nxt_reqState = frfr_pkg::FRFR_REQ_ON;
        frfr_pkg::FRFR_REQ_ON:
          if (modeCfg_ff[frfr_pkg::BURST_BIT])
          begin
            if (xferDone)
              nxt_reqState = frfr_pkg::FRFR_REQ_IDLE;
          end
          else if (portAccess)
          begin
            // Count starts one short: the cycle entering the gap is already quiet
            nxt_reqState = frfr_pkg::FRFR_REQ_GAP;
            nxt_gapCount = 16'(GAP_COUNT - 1);
          end
        frfr_pkg::FRFR_REQ_GAP:
          if (gapCount_ff == 16'h0000)
            nxt_reqState = byteWanted ? frfr_pkg::FRFR_REQ_ON : frfr_pkg::FRFR_REQ_IDLE;
          else
            nxt_gapCount = gapCount_ff - 16'h0001;
        default:
          nxt_reqState = frfr_pkg::FRFR_REQ_IDLE;
      endcase
    end
  end

  // Request pin is a flop of its own, so the host never sees a decode glitch
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reqState_ff <= frfr_pkg::FRFR_REQ_IDLE;
      gapCount_ff <= 16'h0000;
      reqOn_ff    <= 1'b0;
    end
    else
    begin
      reqState_ff <= nxt_reqState;
      gapCount_ff <= nxt_gapCount;
      reqOn_ff    <= nxt_reqState == frfr_pkg::FRFR_REQ_ON;
    end
  end

  // Read mux; compatible-mode input status drives bits 6:0 as zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdData_ff <= 8'h00;
      rdOe_ff   <= 1'b1;
    end
    else if (rdStrobe && cfgSpace)
    begin
      rdOe_ff <= 1'b0;
      if (addr == frfr_pkg::ADDR_BUF_CONFIG)
        rdData_ff <= {2'h0, bufDisable_ff, bufLock_ff, buffer_threshold_ff};
      else if (addr == frfr_pkg::ADDR_MODE_CONFIG)
        rdData_ff <= {3'h0, modeCfg_ff};
      else if (addr == frfr_pkg::ADDR_PRECOMP_TRACK)
        rdData_ff <= preTrack_ff;
      else if (addr == frfr_pkg::ADDR_PHASE)
        rdData_ff <= {6'h00, phase_ff};
      else
        rdData_ff <= {lowPower_ff, illegal_ff, bufActive_ff, precomp_ff, rate_ff};
    end
    else if (rdStrobe && addr == frfr_pkg::ADDR_INPUT_STATUS)
    begin
      rdOe_ff <= 1'b0;
      if (modeCfg_ff[frfr_pkg::ALT_MODE_BIT])
        rdData_ff <= {diskChangedIn, 4'hf, rate_ff,
                      rate_ff == frfr_pkg::RATE_300K || rate_ff == frfr_pkg::RATE_250K};
      else
        rdData_ff <= {diskChangedIn, 7'h00};
    end
    else if (rdStrobe && addr == frfr_pkg::ADDR_MAIN_STATUS)
    begin
      rdOe_ff   <= 1'b0;
      rdData_ff <= mainStatusIn;
    end
    else if (rdStrobe && addr == frfr_pkg::ADDR_DATA_PORT)
    begin
      rdOe_ff   <= 1'b0;
      rdData_ff <= coreDataIn;
    end
    else
    begin
      rdOe_ff   <= 1'b1;
      rdData_ff <= 8'h00;
    end
  end

  // Core picks the byte up one cycle after the host's write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      portData_ff  <= 8'h00;
      portWrite_ff <= 1'b0;
    end
    else
    begin
      portWrite_ff <= portWr;
      if (portWr)
        portData_ff <= wrData;
    end
  end

  assign rdData          = rdData_ff;
  assign rdDataOe_n      = rdOe_ff;
  assign portData        = portData_ff;
  assign portWrite       = portWrite_ff;
  assign softReset       = softReset_ff;
  assign lowPower        = lowPower_ff;
  assign rateSelect      = rate_ff;
  assign precompCode     = precomp_ff;
  assign precompTrack    = preTrack_ff;
  assign bufferActive    = bufActive_ff;
  assign bufferThreshold = effThresh_ff;
  assign transferRequest = reqOn_ff;
  assign rateIllegal     = illegal_ff;

endmodule : frfr_regs

// ### logic/frfr_pkg.sv
// Constants shared by the floppy rate and data-port register block
package frfr_pkg;
  localparam logic [2:0] ADDR_RATE_PRECOMP  = 3'h4;
  localparam logic [2:0] ADDR_DATA_PORT     = 3'h5;
  localparam logic [2:0] ADDR_INPUT_STATUS  = 3'h7;
  localparam logic [2:0] ADDR_RATE_SELECT   = 3'h7;
  localparam logic [2:0] ADDR_MAIN_STATUS   = 3'h4;
  localparam logic [2:0] ADDR_BUF_CONFIG    = 3'h0;
  localparam logic [2:0] ADDR_MODE_CONFIG   = 3'h1;
  localparam logic [2:0] ADDR_PRECOMP_TRACK = 3'h2;
  localparam logic [2:0] ADDR_PHASE         = 3'h3;

  localparam int SWRESET_BIT  = 7;
  localparam int LOWPOWER_BIT = 6;
  localparam int PRECOMP_HI   = 4;
  localparam int PRECOMP_LO   = 2;
  localparam int BUF_DISABLE_BIT = 5;
  localparam int BUF_LOCK_BIT    = 4;
  localparam int BURST_BIT       = 0;
  localparam int RD_BUF_OFF_BIT  = 1;
  localparam int WR_BUF_OFF_BIT  = 2;
  localparam int ALT_MODE_BIT    = 3;
  localparam int FM_BIT          = 4;

  localparam logic [7:0] RATE_PRECOMP_RST = 8'h02;
  localparam logic [1:0] RATE_RST         = 2'h2;
  localparam logic [3:0] BUFFER_THRESHOLD_RST       = 4'h0;
  localparam logic [7:0] PRE_TRACK_RST    = 8'h00;

  localparam logic [1:0] RATE_1M   = 2'h3;
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;

  localparam logic [2:0] PRECOMP_ZERO    = 3'h7;
  localparam logic [2:0] PRECOMP_DEFAULT = 3'h0;
  localparam logic [2:0] PRECOMP_STEP1   = 3'h1;
  localparam logic [2:0] PRECOMP_STEP3   = 3'h3;

  localparam int CLK_MHZ      = 250;
  localparam int GAP_NS       = 350;
  localparam int GAP_CYCLES   = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int BUF_DEPTH    = 16;

  typedef enum logic [1:0]
  {
    FRFR_PH_COMMAND   = 2'b00,
    FRFR_PH_EXECUTION = 2'b01,
    FRFR_PH_RESULT    = 2'b10
  } frfr_phase_e;

  typedef enum logic [1:0]
  {
    FRFR_REQ_IDLE  = 2'b00,
    FRFR_REQ_ON    = 2'b01,
    FRFR_REQ_GAP   = 2'b10
  } frfr_req_e;
endpackage : frfr_pkg

// ### verification/frfr_regs_asserts.sv
// Concurrent checks on the rate and data-port register block
`timescale 1ns/1ns
module frfr_regs_asserts (
  input wire logic       clk,         // Block clock
  input wire logic       reset_n,     // Hardware reset
  input wire logic [2:0] addr,        // Register address
  input wire logic [7:0] wrData,      // Write data
  input wire logic       wrStrobe,    // Write strobe
  input wire logic       rdStrobe,    // Read strobe
  input wire logic       cfgSpace,    // Config space select
  input wire logic       dorReset,    // Output-register reset request
  input wire logic       rdDataOe_n,  // Read data driven when low
  input wire logic       softReset,   // Controller reset pulse
  input wire logic       lowPower,    // Low-power state
  input wire logic [1:0] rateSelect,  // Active rate code
  input wire logic [2:0] precompCode  // Resolved precompensation
);
  wire rpW   = wrStrobe && !cfgSpace && addr == frfr_pkg::ADDR_RATE_PRECOMP;
  wire rateW = rpW || (wrStrobe && !cfgSpace && addr == frfr_pkg::ADDR_RATE_SELECT);
  wire wake  = !cfgSpace && ((addr == frfr_pkg::ADDR_DATA_PORT && (wrStrobe || rdStrobe))
               || (rdStrobe && addr == frfr_pkg::ADDR_MAIN_STATUS));

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // The quiet cycle keeps a rate-only write from changing the default delay
  sequence sPcWr;
    rpW ##1 !wrStrobe;
  endsequence
  sequence sLowWr;
    rpW && wrData[6];
  endsequence

  a_soft_cause: assert property (softReset |-> $past(rpW && wrData[7] || dorReset))
    else $error("Soft reset pulse with no cause");
  a_soft_start: assert property (rpW && wrData[7] |=> softReset)
    else $error("Soft reset bit gave no pulse");
  a_low_enter: assert property (sLowWr |=> lowPower)
    else $error("Low power not entered");
  a_low_exit: assert property (softReset && !wrStrobe |=> !lowPower)
    else $error("Soft reset left low power on");
  a_access_wake: assert property (wake |=> !lowPower)
    else $error("Port access left low power on");
  a_rate_follow: assert property (rateW |=> rateSelect == $past(wrData[1:0]))
    else $error("Rate does not follow last write");
  a_rate_hold: assert property (!$stable(rateSelect) |-> $past(rateW))
    else $error("Rate changed without a rate write");
  a_precomp_resolve: assert property (sPcWr |=> precompCode ==
      (($past(wrData[4:2], 2) != 3'h0) ? $past(wrData[4:2], 2) :
      ($past(wrData[1:0], 2) == 2'h3) ? 3'h1 : 3'h3))
    else $error("Precompensation code wrong");
  a_read_window: assert property (!rdDataOe_n |-> $past(rdStrobe))
    else $error("Read data driven without a read");
endmodule : frfr_regs_asserts

bind frfr_regs frfr_regs_asserts u_asserts (.*);

// ### verification/frfr_host.sv
// Host bus model issuing register writes and reads
`timescale 1ns/1ns
module frfr_host (
  input  wire logic       clk,        // Bus clock
  input  wire logic [7:0] rdData,     // Read data from the block
  input  wire logic       rdDataOe_n, // Read data driven when low
  output logic [2:0]      addr,       // Register address
  output logic [7:0]      wrData,     // Write data
  output logic            wrStrobe,   // One-cycle write strobe
  output logic            rdStrobe,   // One-cycle read strobe
  output logic            cfgSpace    // Config space select
);
  initial
  begin
    addr = 3'h0;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    cfgSpace = 1'b0;
  end

  task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    cfgSpace <= c;
    addr <= a;
    wrData <= v;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    #1;
  endtask : wr

  // Data is taken just after the edge, while it stands for its one cycle
  task automatic rd(input logic c, input logic [2:0] a, output logic [7:0] v, output logic o);
    @(posedge clk);
    cfgSpace <= c;
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    v = rdData;
    o = rdDataOe_n;
  endtask : rd

  task automatic cmdByte(input logic [7:0] v);
    logic [7:0] s = 8'h00;
    logic       o;
    for (int k = 0; k < 8 && s[7] !== 1'b1; k++)
      rd(1'b0, frfr_pkg::ADDR_MAIN_STATUS, s, o);
    wr(1'b0, frfr_pkg::ADDR_DATA_PORT, v);
  endtask : cmdByte
endmodule : frfr_host

// ### verification/testbench.sv
// Self-checking bench for the rate and data-port register block
`timescale 1ns/1ns
module testbench;
  localparam int GAPN = 4;
  logic        clk, reset_n, wrStrobe, rdStrobe, cfgSpace, diskChangedIn, dorReset;
  logic        xferDone, byteWanted, xferIsRead, rdDataOe_n, portWrite, softReset;
  logic        lowPower, bufferActive, rateIllegal, transferRequest, oe;
  logic [2:0]  addr, precompCode;
  logic [7:0]  wrData, rdData, portData, mainStatusIn, coreDataIn, precompTrack, d;
  logic [1:0]  rateSelect;
  logic [3:0]  bufferThreshold;
  logic [31:0] seed = 32'h478a8103;
  logic [31:0] r;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          mRate = 2;
  int          mPc = 0;
  int          n;

  frfr_regs #(.GAP_COUNT(GAPN)) dut (.*);
  frfr_host host (.*);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  task automatic pulseDor();
    @(posedge clk);
    dorReset <= 1'b1;
    @(posedge clk);
    dorReset <= 1'b0;
    #1;
  endtask : pulseDor

  task automatic dsr(input logic [1:0] top);
    host.wr(1'b0, frfr_pkg::ADDR_RATE_PRECOMP, {top, 1'b0, 3'(mPc), 2'(mRate)});
  endtask : dsr

  task automatic results();
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  initial
  begin
    repeat (4000) @(posedge clk);
    fail_count++;
    results();
  end

  initial
  begin
    reset_n = 1'b0;
    {diskChangedIn, dorReset, xferDone, byteWanted, xferIsRead} = 5'h00;
    mainStatusIn = 8'h80;
    coreDataIn = 8'h3c;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    chk("reset", {rateSelect, precompCode, precompTrack}, 16'h1300);
    chk("bufreset", {bufferActive, bufferThreshold}, 12'h000);
    host.wr(1'b1, frfr_pkg::ADDR_MODE_CONFIG, 8'h18);
    for (int i = 0; i < 12; i++)
    begin
      r = xs();
      @(posedge clk);
      diskChangedIn <= r[8];
      mRate = (i < 8) ? ((i + 3) % 4) : r[1:0];
      if (i >= 8 && r[9])
        host.wr(1'b0, frfr_pkg::ADDR_RATE_SELECT, {6'h00, 2'(mRate)});
      else
      begin
        mPc = (i < 8) ? i : r[4:2];
        dsr(2'b00);
      end
      settle();
      chk("rate", rateSelect, mRate);
      chk("precomp", precompCode, (mPc != 0) ? mPc : (mRate == 3) ? 1 : 3);
      chk("illegal", rateIllegal, mRate == 3);
      host.rd(1'b0, frfr_pkg::ADDR_INPUT_STATUS, d, oe);
      chk("diag", {d, oe}, {r[8], 4'hf, 2'(mRate), mRate == 1 || mRate == 2, 1'b0});
    end
    host.wr(1'b1, frfr_pkg::ADDR_MODE_CONFIG, 8'h00);
    host.rd(1'b0, frfr_pkg::ADDR_INPUT_STATUS, d, oe);
    chk("compat", {d[7], oe}, {diskChangedIn, 1'b0});
    host.wr(1'b0, 3'h6, 8'h03);
    host.rd(1'b0, 3'h6, d, oe);
    chk("unmapped", {rateSelect, d, oe}, {2'(mRate), 9'h001});
    dsr(2'b01);
    chk("lowpower", lowPower, 1'b1);
    host.rd(1'b0, frfr_pkg::ADDR_DATA_PORT, d, oe);
    chk("wake", lowPower, 1'b0);
    dsr(2'b01);
    host.rd(1'b0, frfr_pkg::ADDR_MAIN_STATUS, d, oe);
    chk("wake", {lowPower, d}, 12'h080);
    dsr(2'b11);
    chk("softreset", softReset, 1'b1);
    settle();
    chk("selfclear", {softReset, lowPower, rateSelect}, mRate);
    pulseDor();
    chk("softreset", softReset, 1'b1);
    host.wr(1'b1, frfr_pkg::ADDR_BUF_CONFIG, 8'h1f);
    host.wr(1'b1, frfr_pkg::ADDR_PHASE, 8'h01);
    settle();
    chk("buffer", {bufferActive, bufferThreshold}, 12'h01f);
    @(posedge clk);
    xferIsRead <= 1'b1;
    host.wr(1'b1, frfr_pkg::ADDR_MODE_CONFIG, 8'h02);
    settle();
    chk("rdoff", bufferActive, 1'b0);
    host.wr(1'b1, frfr_pkg::ADDR_MODE_CONFIG, 8'h04);
    settle();
    chk("wroff", bufferActive, 1'b1);
    for (int p = 2; p >= 0; p--)
    begin
      host.wr(1'b1, frfr_pkg::ADDR_PHASE, 8'(p));
      settle();
      chk("phase", bufferActive, p == 1);
    end
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
        host.wr(1'b1, frfr_pkg::ADDR_BUF_CONFIG, 8'h0f);
      pulseDor();
      host.wr(1'b1, frfr_pkg::ADDR_PHASE, 8'h01);
      settle();
      chk("lock", {bufferActive, bufferThreshold}, (k == 0) ? 12'h01f : 12'h000);
    end
    @(posedge clk);
    byteWanted <= 1'b1;
    settle();
    chk("request", transferRequest, 1'b1);
    host.rd(1'b0, frfr_pkg::ADDR_DATA_PORT, d, oe);
    n = 0;
    while (transferRequest !== 1'b1 && n < 20)
    begin
      n++;
      settle();
    end
    chk("gap", n, GAPN);
    host.wr(1'b1, frfr_pkg::ADDR_MODE_CONFIG, 8'h05);
    repeat (3)
    begin
      host.rd(1'b0, frfr_pkg::ADDR_DATA_PORT, d, oe);
      chk("burst", transferRequest, 1'b1);
    end
    @(posedge clk);
    xferDone <= 1'b1;
    @(posedge clk);
    xferDone <= 1'b0;
    #1;
    chk("burstend", transferRequest, 1'b0);
    host.wr(1'b1, frfr_pkg::ADDR_PHASE, 8'h00);
    host.cmdByte(8'h5a);
    chk("port", {portWrite, portData}, 12'h15a);
    host.wr(1'b1, frfr_pkg::ADDR_PRECOMP_TRACK, r[7:0]);
    chk("track", precompTrack, r[7:0]);
    results();
  end
endmodule : testbench
